// file: psr_latch_bit.sv
// Latching status bit: latches high or low until a read, then follows live.
// Assumes read strobe is a single-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
module psr_latch_bit #(
   parameter logic LATCH_HIGH = 1'b1,
   parameter logic RST_VAL    = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic event_in,
   input  wire logic live_in,
   input  wire logic rd_clr,
   output var  logic q_ff
);
   logic nxt_q;
   wire  hit = LATCH_HIGH ? event_in : ~event_in;
   // Event wins over read clear
   assign nxt_q = hit ? LATCH_HIGH : (rd_clr ? live_in : q_ff);
   always_ff @(posedge core_clk) begin
      if (sys_rst) q_ff <= RST_VAL;
      else q_ff <= nxt_q;
   end
endmodule // psr_latch_bit
`default_nettype wire

// file: psr_pkg.sv
// Constants for the PHY status and identifier register bank.
// Assumes a serial management interface clocked from the station's own clock.
// Notes on behaviour
// - Status bit 6 reports preamble-suppression capability; resets to zero.
// - Preamble-suppression bit is writable only with override enable set.
// - Negotiation-complete bit held zero while negotiation is disabled.
// - Negotiation-complete set only when the negotiation machine finishes.
// - Negotiation-complete latches high; restart does not clear it; reread shows live.
// - Remote-fault bit is set by the fault flag of a received code word and holds until read.
// - Remote-fault is one latching-high element seen in status and detailed status.
// - Non-latching remote-fault copy at partner bit 13, updated per code word.
// - Negotiation-ability bit always reads one.
// - Link status one when valid, latches low, mirrored in detailed status bit 0.
// - Link monitor input feeds the link-status latch; a drop holds the bit low until read.
// - Jabber inhibit zero disables detection and forces jabber bit zero.
// - Jabber inhibit one sets jabber bit on a jabber condition, else unchanged.
// - Jabber bit latches high, seen in status and detailed status; read clears.
// - Extended-capability bit always reads one.
// - Two identifier registers form a 32-bit identifier.
// - Identifier bits always readable; writable only with override enable.
// - First identifier register at address 2 holds identifier bits 3 to 18.
// - Writes to override-writable bits ignored while override enable is zero.
// - Access over serial management; reset loads every bit's default.
package psr_pkg;
   localparam logic [4:0]  REG_STATUS      = 5'h01;
   localparam logic [4:0]  REG_ID_HIGH     = 5'h02;
   localparam logic [4:0]  REG_PARTNER     = 5'h05;
   localparam logic [4:0]  REG_EXT_CTRL    = 5'h10;
   localparam logic [4:0]  REG_DETAIL      = 5'h11;
   localparam logic [4:0]  REG_TEN_OPS     = 5'h12;
   localparam int          BIT_PRE_SUPP    = 6;
   localparam int          BIT_AN_DONE     = 5;
   localparam int          BIT_RFAULT      = 4;
   localparam int          BIT_AN_ABLE     = 3;
   localparam int          BIT_LINK        = 2;
   localparam int          BIT_JABBER      = 1;
   localparam int          BIT_EXT_CAP     = 0;
   localparam int          BIT_D_JABBER    = 2;
   localparam int          BIT_D_RFAULT    = 1;
   localparam int          BIT_D_LINK      = 0;
   localparam int          BIT_P_RFAULT    = 13;
   localparam int          BIT_OVR_EN      = 15;
   localparam int          BIT_JAB_INH     = 5;
   localparam logic [15:0] ID_HIGH_RST     = 16'h1234;  // Arbitrary value
   localparam logic        JAB_INH_RST     = 1'b1;
   localparam logic [1:0]  ST_START        = 2'h0;
   localparam logic [1:0]  ST_OP           = 2'h1;
   localparam logic [1:0]  ST_TA           = 2'h2;
   localparam int          FRAME_BITS      = 32;
endpackage

// file: psr_station.sv
// Management station model driving the serial management clock and data line.
// Assumes a pull-up on the shared data line and a device address set by the bench.
`timescale 1ns/1ps
`default_nettype none
module psr_station (
   input  wire logic core_clk,
   input  wire logic mdio_o,
   input  wire logic mdio_oe_n,
   output var  logic mdc,
   output var  logic mdio_line
);
   logic sta_drv = 1'b1;
   logic sta_out = 1'b1;
   // Resolved line level, pulled up when released
   always_comb mdio_line = !mdio_oe_n ? mdio_o : (sta_drv ? sta_out : 1'b1);
   initial mdc = 1'b0;
   // One whole frame, clock stands low outside it
   task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
      logic [39:0] fr;
      fr = {8'hFF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
      rdat = 16'h0000;
      for (int i = 39; i >= 0; i--) begin
         @(posedge core_clk);
         sta_drv <= !(rd && i < 18);
         sta_out <= fr[i];
         repeat (3) @(posedge core_clk);
         mdc <= 1'b1;
         repeat (3) @(posedge core_clk);
         if (i < 16) rdat[i] = mdio_line;
         @(posedge core_clk);
         mdc <= 1'b0;
      end
      @(posedge core_clk);
      sta_drv <= 1'b1;
      sta_out <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
endmodule // psr_station
`default_nettype wire

// file: psr_status_id.sv
// PHY status and first identifier registers behind a serial management port.
// Assumes mdc and mdio come from the station; detectors feed the event inputs.
`timescale 1ns/1ps
`default_nettype none
module psr_status_id
   import psr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       mdc,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe_n,
   input  wire logic [4:0] phy_addr,
   input  wire logic       an_enable,
   input  wire logic       an_done,
   input  wire logic       code_word_stb,
   input  wire logic       code_word_rfault,
   input  wire logic       link_valid,
   input  wire logic       jabber_event,
   output var  logic       pre_supp_en,
   output var  logic       jabber_enable
);
   import psr_pkg::*;
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_HDR = 2'b01, S_DATA = 2'b10} psr_state_t;

   logic       mdc_s;
   logic       mdio_s;
   logic       mdc_d_ff;
   psr_state_t state_ff;
   logic [5:0] cnt_ff;
   logic [15:0] shift_ff;
   logic       is_read_ff;
   logic [4:0] reg_ff;
   logic       mine_ff;
   logic       drive_ff;
   logic       out_ff;
   logic       pre_supp_ff;
   logic [15:0] id_high_ff;
   logic       ovr_en_ff;
   logic       jab_inh_ff;
   logic       rfault_copy_ff;
   logic       an_done_q;
   logic       rfault_q;
   logic       link_q;
   logic       jabber_q;
   logic       rd_stb_ff;
   logic [4:0] rd_reg_ff;
   logic       wr_stb;

   psr_sync u_sync_mdc  (.core_clk(core_clk), .sys_rst(sys_rst), .din(mdc),    .dout(mdc_s));
   psr_sync u_sync_mdio (.core_clk(core_clk), .sys_rst(sys_rst), .din(mdio_i), .dout(mdio_s));

   wire rise = mdc_s & ~mdc_d_ff;
   wire fall = ~mdc_s & mdc_d_ff;

   // Frame decode at last address bit: ST(2) OP(2) PHYAD(5) REGAD(5), TA still to come
   wire [15:0] hdr_next = {shift_ff[14:0], mdio_s};
   wire        hdr_ok   = (hdr_next[13:12] == 2'b01);
   wire        hdr_rd   = (hdr_next[11:10] == 2'b10);
   wire        hdr_mine = (hdr_next[9:5] == phy_addr);
   wire [4:0]  hdr_reg  = hdr_next[4:0];
   wire        data_done = rise && state_ff == S_DATA && cnt_ff == 6'd15;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mdc_d_ff <= 1'b0;
         state_ff <= S_IDLE;
         cnt_ff   <= 6'd0;
         shift_ff <= 16'h0000;
         is_read_ff <= 1'b0;
         reg_ff   <= 5'h00;
         mine_ff  <= 1'b0;
         rd_stb_ff <= 1'b0;
         rd_reg_ff <= 5'h00;
      end else begin
         mdc_d_ff  <= mdc_s;
         rd_stb_ff <= 1'b0;
         if (rise) begin
            shift_ff <= hdr_next;
            case (state_ff)
               S_IDLE: begin
                  // Preamble-less frames: start on first zero (idle is ones)
                  if (!mdio_s) begin
                     state_ff <= S_HDR;
                     cnt_ff   <= 6'd1;
                  end
               end
               S_HDR: begin
                  cnt_ff <= cnt_ff + 6'd1;
                  if (cnt_ff == 6'd13) begin
                     if (!hdr_ok) state_ff <= S_IDLE;
                     is_read_ff <= hdr_rd;
                     mine_ff    <= hdr_mine;
                     reg_ff     <= hdr_reg;
                     if (hdr_rd && hdr_mine) begin
                        rd_stb_ff <= 1'b1;
                        rd_reg_ff <= hdr_reg;
                     end
                  end
                  if (cnt_ff == 6'd15) begin
                     state_ff <= S_DATA;
                     cnt_ff   <= 6'd0;
                  end
               end
               S_DATA: begin
                  cnt_ff <= cnt_ff + 6'd1;
                  if (cnt_ff == 6'd15) state_ff <= S_IDLE;
               end
               default: state_ff <= S_IDLE;
            endcase
         end
      end
   end

   assign wr_stb = data_done && !is_read_ff && mine_ff;
   wire   wr_ovr = wr_stb && ovr_en_ff;
   wire   rd_status = rd_stb_ff && rd_reg_ff == REG_STATUS;
   wire   rd_detail = rd_stb_ff && rd_reg_ff == REG_DETAIL;
   wire   rd_clr_sd = rd_status | rd_detail;
   wire   rd_clr_st = rd_status;

   // Latched status bits
   wire an_live = an_enable & an_done;
   psr_latch_bit #(.LATCH_HIGH(1'b1), .RST_VAL(1'b0)) u_an (
      .core_clk(core_clk), .sys_rst(sys_rst), .event_in(an_live),
      .live_in(an_live), .rd_clr(rd_clr_st), .q_ff(an_done_q));
   wire rf_ev = code_word_stb & code_word_rfault;
   psr_latch_bit #(.LATCH_HIGH(1'b1), .RST_VAL(1'b0)) u_rf (
      .core_clk(core_clk), .sys_rst(sys_rst), .event_in(rf_ev),
      .live_in(rfault_copy_ff), .rd_clr(rd_clr_sd), .q_ff(rfault_q));
   psr_latch_bit #(.LATCH_HIGH(1'b0), .RST_VAL(1'b0)) u_lk (
      .core_clk(core_clk), .sys_rst(sys_rst), .event_in(link_valid),
      .live_in(link_valid), .rd_clr(rd_clr_sd), .q_ff(link_q));
   wire jab_ev = jab_inh_ff & jabber_event;
   psr_latch_bit #(.LATCH_HIGH(1'b1), .RST_VAL(1'b0)) u_jb (
      .core_clk(core_clk), .sys_rst(sys_rst), .event_in(jab_ev),
      .live_in(1'b0), .rd_clr(rd_clr_sd), .q_ff(jabber_q));

   wire an_bit  = an_enable & an_done_q;
   wire jab_bit = jab_inh_ff & jabber_q;

   // Writable registers and the remote-fault copy
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pre_supp_ff    <= 1'b0;
         id_high_ff     <= ID_HIGH_RST;
         ovr_en_ff      <= 1'b0;
         jab_inh_ff     <= JAB_INH_RST;
         rfault_copy_ff <= 1'b0;
      end else begin
         if (code_word_stb) rfault_copy_ff <= code_word_rfault;
         if (wr_ovr && reg_ff == REG_STATUS) pre_supp_ff <= hdr_next[BIT_PRE_SUPP];
         if (wr_ovr && reg_ff == REG_ID_HIGH) id_high_ff <= hdr_next;
         if (wr_stb && reg_ff == REG_EXT_CTRL) ovr_en_ff <= hdr_next[BIT_OVR_EN];
         if (wr_stb && reg_ff == REG_TEN_OPS) jab_inh_ff <= hdr_next[BIT_JAB_INH];
      end
   end

   // Read data, captured at end of header before the clear takes effect
   logic [15:0] status_word;
   logic [15:0] detail_word;
   logic [15:0] rd_word;
   always_comb begin
      status_word = 16'h0000;
      status_word[BIT_PRE_SUPP] = pre_supp_ff;
      status_word[BIT_AN_DONE]  = an_bit;
      status_word[BIT_RFAULT]   = rfault_q;
      status_word[BIT_AN_ABLE]  = 1'b1;
      status_word[BIT_LINK]     = link_q;
      status_word[BIT_JABBER]   = jab_bit;
      status_word[BIT_EXT_CAP]  = 1'b1;
      detail_word = 16'h0000;
      detail_word[BIT_D_JABBER] = jab_bit;
      detail_word[BIT_D_RFAULT] = rfault_q;
      detail_word[BIT_D_LINK]   = link_q;
   end
   assign rd_word = (hdr_reg == REG_STATUS) ? status_word :
                    (hdr_reg == REG_ID_HIGH) ? id_high_ff :
                    (hdr_reg == REG_PARTNER) ? {2'b00, rfault_copy_ff, 13'h0000} :
                    (hdr_reg == REG_EXT_CTRL) ? {ovr_en_ff, 15'h0000} :
                    (hdr_reg == REG_DETAIL) ? detail_word :
                    (hdr_reg == REG_TEN_OPS) ? {10'h000, jab_inh_ff, 5'h00} : 16'h0000;

   logic [15:0] out_sh_ff;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         out_sh_ff <= 16'h0000;
         drive_ff  <= 1'b0;
         out_ff    <= 1'b1;
      end else begin
         if (rise && state_ff == S_HDR && cnt_ff == 6'd13) out_sh_ff <= rd_word;
         if (fall && state_ff == S_HDR && cnt_ff == 6'd15 && is_read_ff && mine_ff) begin
            drive_ff <= 1'b1;
            out_ff   <= 1'b0;
         end else if (fall && state_ff == S_DATA && drive_ff) begin
            out_ff    <= out_sh_ff[15];
            out_sh_ff <= {out_sh_ff[14:0], 1'b0};
         end
         if (state_ff == S_IDLE) drive_ff <= 1'b0;
      end
   end

   assign mdio_o        = out_ff;
   assign mdio_oe_n     = ~drive_ff;
   assign pre_supp_en   = pre_supp_ff;
   assign jabber_enable = jab_inh_ff;

   AST_AN_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
      !an_enable |-> !status_word[BIT_AN_DONE]) else $error("an done set while disabled");
   AST_AN_LATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
      (an_live && !rd_clr_st) |=> an_done_q) else $error("an done not latched");
   AST_RF_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      rf_ev |=> rfault_q && rfault_copy_ff) else $error("remote fault not set");
   AST_RF_COPY: assert property (@(posedge core_clk) disable iff (sys_rst)
      code_word_stb |=> rfault_copy_ff == $past(code_word_rfault)) else $error("copy wrong");
   AST_LINK_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!link_valid ##1 !rd_clr_sd) |=> !link_q) else $error("link drop lost");
   AST_JAB_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
      !jab_inh_ff |-> !status_word[BIT_JABBER] && !detail_word[BIT_D_JABBER]) else $error("jabber shown");
   AST_JAB_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      (jab_ev && jab_inh_ff) |=> jabber_q) else $error("jabber not latched");
   AST_FIXED: assert property (@(posedge core_clk) disable iff (sys_rst)
      status_word[BIT_AN_ABLE] && status_word[BIT_EXT_CAP]) else $error("fixed ones wrong");
   AST_ID_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ovr_en_ff |=> $stable(id_high_ff) && $stable(pre_supp_ff)) else $error("locked write");
endmodule // psr_status_id
`default_nettype wire

// file: psr_status_id_test.sv
// Self-checking bench for the status and identifier register bank.
// Assumes the station model in psr_station and the package constants.
`timescale 1ns/1ps
`default_nettype none
module psr_status_id_test;
   import psr_pkg::*;
   logic        core_clk, sys_rst, mdc, mdio_line, mdio_o, mdio_oe_n, pre_supp_en, jabber_enable;
   logic        an_enable, an_done, code_word_stb, code_word_rfault, link_valid, jabber_event;
   logic [4:0]  phy_addr;
   logic [15:0] rd;
   int          bad_count = 0;
   int          samples_checked = 0;

   psr_status_id u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_i(mdio_line),
      .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr), .an_enable(an_enable),
      .an_done(an_done), .code_word_stb(code_word_stb), .code_word_rfault(code_word_rfault),
      .link_valid(link_valid), .jabber_event(jabber_event), .pre_supp_en(pre_supp_en),
      .jabber_enable(jabber_enable));
   psr_station u_sta (.core_clk(core_clk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
      .mdio_line(mdio_line));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
      samples_checked++;
      if ((got & m) !== (exp & m)) begin
         bad_count++;
         $display("Error at %0t: read %h expected %h mask %h", $time, got, exp, m);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp, input logic [15:0] m);
      u_sta.xfer(1'b1, phy_addr, ra, 16'h0000, rd);
      check_reg(rd, exp, m);
      check_bit(mdio_oe_n, 1'b1);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      u_sta.xfer(1'b0, phy_addr, ra, d, rd);
   endtask
   task automatic cw(input logic f);
      code_word_rfault <= f;
      code_word_stb <= 1'b1;
      @(posedge core_clk) code_word_stb <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic blip_jab();
      jabber_event <= 1'b1;
      @(posedge core_clk) jabber_event <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic t_reset();
      rd_chk(REG_STATUS, 16'h0009, 16'h007F);
      check_bit(pre_supp_en, 1'b0);
      check_bit(jabber_enable, JAB_INH_RST);
      rd_chk(REG_ID_HIGH, ID_HIGH_RST, 16'hFFFF);
      u_sta.xfer(1'b1, phy_addr ^ 5'h04, REG_STATUS, 16'h0000, rd);
      check_reg(rd, 16'hFFFF, 16'hFFFF);
      rd_chk(5'h1F, 16'h0000, 16'hFFFF);
      $display("test reset done");
   endtask
   task automatic t_override();
      link_valid <= 1'b1;
      wr(REG_ID_HIGH, 16'hA5C3);
      wr(REG_STATUS, 16'h0040);
      rd_chk(REG_ID_HIGH, ID_HIGH_RST, 16'hFFFF);
      rd_chk(REG_STATUS, 16'h0009, 16'h007F);
      check_bit(pre_supp_en, 1'b0);
      wr(REG_EXT_CTRL, 16'h8000);
      wr(REG_ID_HIGH, 16'hA5C3);
      wr(REG_STATUS, 16'h0040);
      rd_chk(REG_ID_HIGH, 16'hA5C3, 16'hFFFF);
      rd_chk(REG_STATUS, 16'h004D, 16'h007F);
      check_bit(pre_supp_en, 1'b1);
      wr(REG_EXT_CTRL, 16'h0000);
      $display("test override done");
   endtask
   task automatic t_an();
      an_done <= 1'b1;
      rd_chk(REG_STATUS, 16'h0000, 16'h0020);
      rd_chk(REG_STATUS, 16'h0000, 16'h0020);
      an_done <= 1'b0;
      an_enable <= 1'b1;
      rd_chk(REG_STATUS, 16'h0000, 16'h0020);
      an_done <= 1'b1;
      rd_chk(REG_STATUS, 16'h0020, 16'h0020);
      repeat (4) @(posedge core_clk);
      an_done <= 1'b0;
      rd_chk(REG_STATUS, 16'h0020, 16'h0020);
      rd_chk(REG_STATUS, 16'h0000, 16'h0020);
      $display("test negotiation done");
   endtask
   task automatic t_rfault();
      cw(1'b1);
      rd_chk(REG_PARTNER, 16'h2000, 16'h2000);
      cw(1'b0);
      rd_chk(REG_PARTNER, 16'h0000, 16'h2000);
      rd_chk(REG_STATUS, 16'h0010, 16'h0010);
      rd_chk(REG_STATUS, 16'h0000, 16'h0010);
      cw(1'b1);
      cw(1'b0);
      rd_chk(REG_DETAIL, 16'h0002, 16'h0002);
      rd_chk(REG_STATUS, 16'h0000, 16'h0010);
      $display("test remote fault done");
   endtask
   task automatic t_link();
      link_valid <= 1'b0;
      @(posedge core_clk) link_valid <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_chk(REG_STATUS, 16'h0000, 16'h0004);
      rd_chk(REG_STATUS, 16'h0004, 16'h0004);
      link_valid <= 1'b0;
      @(posedge core_clk) link_valid <= 1'b1;
      rd_chk(REG_DETAIL, 16'h0000, 16'h0001);
      rd_chk(REG_DETAIL, 16'h0001, 16'h0001);
      $display("test link done");
   endtask
   task automatic t_jabber();
      blip_jab();
      rd_chk(REG_STATUS, 16'h0002, 16'h0002);
      rd_chk(REG_STATUS, 16'h0000, 16'h0002);
      blip_jab();
      rd_chk(REG_DETAIL, 16'h0004, 16'h0004);
      rd_chk(REG_STATUS, 16'h0000, 16'h0002);
      wr(REG_TEN_OPS, 16'h0000);
      check_bit(jabber_enable, 1'b0);
      blip_jab();
      rd_chk(REG_STATUS, 16'h0000, 16'h0002);
      wr(REG_TEN_OPS, 16'h0020);
      check_bit(jabber_enable, 1'b1);
      rd_chk(REG_STATUS, 16'h0000, 16'h0002);
      $display("test jabber done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      sys_rst = 1'b1;
      phy_addr = 5'h01;
      {an_enable, an_done, code_word_stb, code_word_rfault, link_valid, jabber_event} = 6'h00;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_override();
      t_an();
      t_rfault();
      t_link();
      t_jabber();
      test_done();
   end
   initial begin
      #300000;
      bad_count++;
      test_done();
   end
endmodule // psr_status_id_test
`default_nettype wire

// file: psr_sync.sv
// Two-flop synchroniser for a single level.
// Assumes the input comes from outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module psr_sync (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic din,
   output var  logic dout
);
   logic meta_ff;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule // psr_sync
`default_nettype wire
